// ==== rtl/rcs_top.sv ====
// reset hold, clock source selection, clock-scaled chopper and step timing, apb registers
//
// Operation
// - power-on reset loads all register defaults
// - supply undervoltage resets all but the apb handshake and pin synchronisers; core supply unmonitored
// - internal clock until first external rising edge
// - chopper and ramp timing follow selected clock
// - calibration velocity gives 780 steps per 100ms
// - chopper stops without clock; short detect continues
`timescale 1ns/1ps
module rcs_top import rcs_pkg::*; #(
	parameter longint unsigned CAL_WINDOW_CYC = CAL_WINDOW_CYC_DEF
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rcs_uv_t supply_uv,
	input wire logic ext_clk_pin,
	input wire logic short_gnd_pin,
	output logic chopper_drive,
	output logic step_pulse,
	output logic logic_rst_n,
	output logic short_gnd_fault
);
	localparam logic [ACC_W-1:0] STEP_THRESH = ACC_W'(CAL_WINDOW_CYC * CAL_VELOCITY);
	localparam logic [ACC_W-1:0] STEP_GAIN = ACC_W'(CAL_STEPS);

	// pin synchronisers; first stage read only by second stage
	rcs_uv_t uv_s1_r, uv_s2_r;
	logic clk_s1_r, clk_s2_r, clk_s3_r;
	logic sg_s1_r, sg_s2_r;
	logic rst_hold_r, rst_hold_nxt;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			uv_s1_r <= '0;
			uv_s2_r <= '0;
			clk_s1_r <= 1'b0;
			clk_s2_r <= 1'b0;
			clk_s3_r <= 1'b0;
			sg_s1_r <= 1'b0;
			sg_s2_r <= 1'b0;
		end else begin
			uv_s1_r <= supply_uv;
			uv_s2_r <= uv_s1_r;
			clk_s1_r <= ext_clk_pin;
			clk_s2_r <= clk_s1_r;
			clk_s3_r <= clk_s2_r;
			sg_s1_r <= short_gnd_pin;
			sg_s2_r <= sg_s1_r;
		end
	end

	// core supply has no monitor, so only three rails feed the hold
	always_comb begin
		rst_hold_nxt = |uv_s2_r;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_hold_r <= 1'b1;
		end else begin
			rst_hold_r <= rst_hold_nxt;
		end
	end

	// clock source selection
	rcs_src_t src_r, src_nxt;
	logic ext_rise;
	logic tick;

	always_comb begin
		// edge found on synced samples, so an external clock must stay well below clk/2
		ext_rise = clk_s2_r & ~clk_s3_r;
		src_nxt = src_r;
		if (rst_hold_r) begin
			src_nxt = SRC_INTERNAL;
		end else begin
			case (src_r)
				SRC_INTERNAL: begin
					if (ext_rise) begin
						src_nxt = SRC_EXTERNAL;
					end
				end
				// sticky until reset; a stopped clock does not fall back to the oscillator
				SRC_EXTERNAL: begin
					src_nxt = SRC_EXTERNAL;
				end
				default: begin
					src_nxt = SRC_INTERNAL;
				end
			endcase
		end
		// a stopped external clock gives no ticks, so all timing freezes
		tick = (src_r == SRC_INTERNAL) ? 1'b1 : ext_rise;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			src_r <= SRC_INTERNAL;
		end else begin
			src_r <= src_nxt;
		end
	end

	// software registers
	logic [CHOPPER_OFF_TIME_W-1:0] chopper_off_time_r, chopper_off_time_nxt;
	logic s2g_en_r, s2g_en_nxt;
	logic [VEL_W-1:0] max_velocity_r, max_velocity_nxt;
	logic [31:0] prdata_nxt;
	logic pready_nxt, pslverr_nxt;
	logic wr_go;
	logic mapped;
	rcs_status_t status;
	logic [POS_W-1:0] pos_r;

	// register select, shared by the read mux and the write path
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] offs);
		return addr == offs;
	endfunction : reg_hit

	// apb: one wait state, pready rises on the second access cycle
	always_comb begin
		chopper_off_time_nxt = chopper_off_time_r;
		s2g_en_nxt = s2g_en_r;
		max_velocity_nxt = max_velocity_r;
		prdata_nxt = prdata;
		pslverr_nxt = 1'b0;
		// ~pready keeps a held access from being answered twice
		pready_nxt = psel & penable & ~pready;
		wr_go = psel & penable & pready & pwrite;
		status = '{short_fault: short_gnd_fault, chopper_on: chopper_drive,
			ext_clk_sel: (src_r == SRC_EXTERNAL), logic_in_reset: rst_hold_r};
		mapped = 1'b1;
		if (reg_hit(paddr, ADDR_CHOP_CFG)) begin
			prdata_nxt = WORD_ZERO;
			prdata_nxt[CHOPPER_OFF_TIME_W-1:0] = chopper_off_time_r;
			prdata_nxt[CFG_S2G_EN_BIT] = s2g_en_r;
		end else if (reg_hit(paddr, ADDR_VELOCITY)) begin
			prdata_nxt = {{(32-VEL_W){1'b0}}, max_velocity_r};
		end else if (reg_hit(paddr, ADDR_POSITION)) begin
			prdata_nxt = pos_r;
		end else if (reg_hit(paddr, ADDR_STATUS)) begin
			prdata_nxt = {{(32-$bits(rcs_status_t)){1'b0}}, status};
		end else begin
			prdata_nxt = WORD_ZERO;
			mapped = 1'b0;
		end
		if (!(psel & penable & ~pready)) begin
			prdata_nxt = prdata;
		end else begin
			pslverr_nxt = ~mapped;
		end
		if (wr_go) begin
			if (reg_hit(paddr, ADDR_CHOP_CFG)) begin
				chopper_off_time_nxt = pwdata[CHOPPER_OFF_TIME_W-1:0];
				s2g_en_nxt = pwdata[CFG_S2G_EN_BIT];
			end else if (reg_hit(paddr, ADDR_VELOCITY)) begin
				max_velocity_nxt = pwdata[VEL_W-1:0];
			end
		end
		if (rst_hold_r) begin
			chopper_off_time_nxt = CHOPPER_OFF_TIME_RESET;
			s2g_en_nxt = 1'b0;
			max_velocity_nxt = VEL_RESET;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			chopper_off_time_r <= CHOPPER_OFF_TIME_RESET;
			s2g_en_r <= 1'b0;
			max_velocity_r <= VEL_RESET;
			prdata <= WORD_ZERO;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			chopper_off_time_r <= chopper_off_time_nxt;
			s2g_en_r <= s2g_en_nxt;
			max_velocity_r <= max_velocity_nxt;
			prdata <= prdata_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
		end
	end

	// chopper: fixed on time, off time from chopper_off_time, both in ticks
	logic [CHOP_CNT_W-1:0] chop_cnt_r, chop_cnt_nxt;
	logic chop_drv_nxt;
	logic [CHOP_CNT_W-1:0] off_ticks;

	// true on the last tick of a phase that lasts len ticks
	function automatic logic phase_end(input logic [CHOP_CNT_W-1:0] cnt,
		input logic [CHOP_CNT_W-1:0] len);
		return cnt >= len - 1'b1;
	endfunction : phase_end

	always_comb begin
		off_ticks = CHOP_CNT_W'({chopper_off_time_r, {OFF_SCALE_SH{1'b0}}});
		chop_cnt_nxt = chop_cnt_r;
		// with no ticks the drive level freezes, hence the host disables it first
		chop_drv_nxt = chopper_drive;
		if (rst_hold_r || chopper_off_time_r == CHOPPER_OFF_TIME_RESET) begin
			chop_cnt_nxt = '0; // zero off time disables the driver
			chop_drv_nxt = 1'b0;
		end else if (tick) begin
			if (chopper_drive && phase_end(chop_cnt_r, CHOP_ON_TICKS)) begin
				chop_cnt_nxt = '0;
				chop_drv_nxt = 1'b0;
			end else if (!chopper_drive && phase_end(chop_cnt_r, off_ticks)) begin
				chop_cnt_nxt = '0;
				chop_drv_nxt = 1'b1;
			end else begin
				chop_cnt_nxt = chop_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			chop_cnt_r <= '0;
			chopper_drive <= 1'b0;
		end else begin
			chop_cnt_r <= chop_cnt_nxt;
			chopper_drive <= chop_drv_nxt;
		end
	end

	// step rate: max_velocity*780 per tick against window*10000 threshold
	logic [ACC_W-1:0] acc_r, acc_nxt, acc_sum;
	logic [POS_W-1:0] pos_nxt;
	logic step_nxt;

	always_comb begin
		acc_sum = acc_r + ACC_W'(max_velocity_r) * STEP_GAIN;
		acc_nxt = acc_r;
		pos_nxt = pos_r;
		step_nxt = 1'b0;
		if (rst_hold_r) begin
			acc_nxt = '0;
			pos_nxt = '0;
		end else if (tick) begin
			if (acc_sum >= STEP_THRESH) begin
				acc_nxt = acc_sum - STEP_THRESH;
				// one step per tick at most; excess dropped so a slow-down acts at once
				if (acc_nxt >= STEP_THRESH) begin
					acc_nxt = '0;
				end
				pos_nxt = pos_r + 1'b1;
				step_nxt = 1'b1;
			end else begin
				acc_nxt = acc_sum;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_r <= '0;
			pos_r <= '0;
			step_pulse <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			pos_r <= pos_nxt;
			step_pulse <= step_nxt;
		end
	end

	// short detect needs no tick, only the enable
	logic sg_fault_nxt;
	logic rst_n_nxt;

	always_comb begin
		sg_fault_nxt = s2g_en_r & sg_s2_r;
		rst_n_nxt = ~rst_hold_r;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			short_gnd_fault <= 1'b0;
			logic_rst_n <= 1'b0;
		end else begin
			short_gnd_fault <= sg_fault_nxt;
			logic_rst_n <= rst_n_nxt;
		end
	end
endmodule : rcs_top

// ==== rtl/rcs_pkg.sv ====
// shared constants and types for the reset and clock source control block
package rcs_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned CAL_WINDOW_MS = 100;
	localparam longint unsigned CAL_WINDOW_CYC_DEF = longint'(CLK_HZ) / 1000 * CAL_WINDOW_MS;
	localparam int unsigned CAL_VELOCITY = 10000;
	localparam int unsigned CAL_STEPS = 780;
	localparam int ACC_W = 40;
	localparam int POS_W = 32;
	localparam int VEL_W = 23;
	localparam int CHOPPER_OFF_TIME_W = 4;
	localparam int CHOP_CNT_W = 10;
	localparam logic [CHOP_CNT_W-1:0] CHOP_ON_TICKS = 10'h018;
	localparam int OFF_SCALE_SH = 5;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CHOP_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_VELOCITY = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_POSITION = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
	localparam int CFG_S2G_EN_BIT = 4;
	localparam logic [CHOPPER_OFF_TIME_W-1:0] CHOPPER_OFF_TIME_RESET = 4'h0;
	localparam logic [VEL_W-1:0] VEL_RESET = 23'h000000;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;

	typedef struct packed {
		logic analog_supply_rail;
		logic regulator_output_rail;
		logic io_supply_rail;
	} rcs_uv_t;

	typedef struct packed {
		logic short_fault;
		logic chopper_on;
		logic ext_clk_sel;
		logic logic_in_reset;
	} rcs_status_t;

	typedef enum logic [1:0] {
		SRC_INTERNAL = 2'b01,
		SRC_EXTERNAL = 2'b10
	} rcs_src_t;
endpackage : rcs_pkg

// ==== verif/rcs_top_chk.sv ====
// port assertions for the reset and clock source control block
`timescale 1ns/1ps
module rcs_top_chk import rcs_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire rcs_uv_t supply_uv,
	input wire logic short_gnd_pin,
	input wire logic chopper_drive,
	input wire logic step_pulse,
	input wire logic logic_rst_n,
	input wire logic short_gnd_fault
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_uv_hold: assert property ((|supply_uv)[*5] |-> !logic_rst_n)
		else $error("reset not held");
	a_uv_release: assert property ((!(|supply_uv))[*7] |-> logic_rst_n)
		else $error("reset not released");
	a_hold_quiet: assert property ((!logic_rst_n)[*2] |-> !chopper_drive && !step_pulse)
		else $error("active in reset");
	a_short_lat: assert property ($rose(short_gnd_fault) |-> $past(short_gnd_pin, 3))
		else $error("fault without short");
	a_wait_state: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("wait state");
	a_pready_once: assert property (pready |=> !pready)
		else $error("pready held");
	a_err_decode: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
		else $error("decode");
	a_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
		else $error("error data");
endmodule : rcs_top_chk
bind rcs_top rcs_top_chk i_rcs_top_chk (.clk, .rstn, .paddr, .psel, .penable, .pwrite, .prdata,
	.pready, .pslverr, .supply_uv, .short_gnd_pin, .chopper_drive, .step_pulse, .logic_rst_n,
	.short_gnd_fault);

// ==== verif/rcs_host_clk.sv ====
// host side clock source, held low while stopped
`timescale 1ns/1ps
module rcs_host_clk (
	input wire logic clk,
	input wire logic run,
	output logic ext_clk_pin
);
	logic [2:0] cnt_r = 3'h0;
	logic pin_r = 1'b0;
	assign ext_clk_pin = pin_r;
	always_ff @(posedge clk) begin
		cnt_r <= cnt_r + 3'h1;
		pin_r <= run & cnt_r[2];
	end
endmodule : rcs_host_clk

// ==== verif/rcs_top_tb.sv ====
// testbench for the reset and clock source control block
`timescale 1ns/1ps
module rcs_top_tb import rcs_pkg::*;;
	localparam int CAL = 2000;
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic run = 1'b0, short_gnd_pin = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd, p0;
	logic pready, pslverr, chopper_drive, step_pulse, logic_rst_n, short_gnd_fault, ext_clk_pin;
	rcs_uv_t supply_uv = 3'h0;
	int miscompares = 0, check_count = 0, seed = 32'hF4AA20EE, i, n, steps = 0, s0;
	initial forever #25 clk = ~clk;
	rcs_top #(.CAL_WINDOW_CYC(CAL)) i_rcs_top (.clk, .rstn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .supply_uv, .ext_clk_pin, .short_gnd_pin,
		.chopper_drive, .step_pulse, .logic_rst_n, .short_gnd_fault);
	rcs_host_clk i_rcs_host_clk (.clk, .run, .ext_clk_pin);
	// step pulses counted on the falling edge, where they are settled
	always @(negedge clk) begin
		if (step_pulse === 1'b1) steps++;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one idle edge before each setup, so psel is never driven twice in a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic end_of_test();
		if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 4; i++) begin
			apb(0, 8'(i * 4), 0);
			chk("reset value", 0, rd);
		end
		for (i = 0; i < 4; i++) begin
			n = $random(seed);
			apb(1, 8'h04, n);
			apb(0, 8'h04, 0);
			chk("velocity", n & 32'h007FFFFF, rd);
		end
		apb(0, 8'h10, 0);
		chk("unmapped error", 1, err);
		chk("unmapped data", 0, rd);
		// take to take is four edges, so the window is exactly CAL cycles
		for (i = 0; i < 3; i++) begin
			n = 10000 >> i;
			apb(1, 8'h04, n);
			apb(0, 8'h08, 0);
			p0 = rd;
			s0 = steps;
			repeat (CAL - 4) @(posedge clk);
			apb(0, 8'h08, 0);
			chk("steps per window", n * 780 / 10000, rd - p0);
			chk("step pulses", n * 780 / 10000, steps - s0);
		end
		apb(1, 8'h00, 1);
		@(posedge chopper_drive) @(negedge clk);
		for (n = 0; chopper_drive === 1'b1; n++) @(negedge clk);
		chk("on time", 24, n);
		apb(1, 8'h00, 32'h10);
		run <= 1'b1;
		repeat (40) @(posedge clk);
		apb(0, 8'h0C, 0);
		chk("clock source", 2, rd & 2);
		run <= 1'b0;
		repeat (20) @(posedge clk);
		apb(0, 8'h08, 0);
		p0 = rd;
		short_gnd_pin <= 1'b1;
		repeat (50) @(posedge clk);
		apb(0, 8'h08, 0);
		chk("frozen position", p0, rd);
		chk("short fault", 1, short_gnd_fault);
		for (i = 0; i < 3; i++) begin
			apb(1, 8'h04, 1234);
			supply_uv <= 3'(1 << i);
			repeat (10) @(posedge clk);
			chk("reset held", 0, logic_rst_n);
			supply_uv <= 3'h0;
			repeat (8) @(posedge clk);
			chk("reset released", 1, logic_rst_n);
			apb(0, 8'h04, 0);
			chk("velocity default", 0, rd);
		end
		apb(0, 8'h0C, 0);
		chk("status default", 0, rd);
		end_of_test();
	end
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
endmodule : rcs_top_tb
